// ==== crcg_cfg.svh ====
/*
 * register map, field positions and sizing constants of the crc generator.
 * assumes a 3-bit word address and 16-bit data on the register port.
 */
`ifndef CRCG_CFG_SVH
`define CRCG_CFG_SVH

// ==========================================================
// register addresses
`define CRCG_ADR_CTRL1     3'h0
`define CRCG_ADR_CTRL2     3'h1
`define CRCG_ADR_TERMS_LO  3'h2
`define CRCG_ADR_TERMS_HI  3'h3
`define CRCG_ADR_DATA_LO   3'h4
`define CRCG_ADR_DATA_HI   3'h5
`define CRCG_ADR_RES_LO    3'h6
`define CRCG_ADR_RES_HI    3'h7

// ==========================================================
// control register one fields
`define CRCG_C1_EN         15
`define CRCG_C1_IDLE       13
`define CRCG_C1_FULL       7
`define CRCG_C1_EMPTY      6
`define CRCG_C1_ISEL       5
`define CRCG_C1_RUN        4
`define CRCG_C1_LSB        3

// ==========================================================
// control register two fields
`define CRCG_C2_WID_HI     12
`define CRCG_C2_WID_LO     8
`define CRCG_C2_LEN_HI     4
`define CRCG_C2_LEN_LO     0

// ==========================================================
// fifo sizing by width field
`define CRCG_WIDE_MIN      5'h10
`define CRCG_MID_MIN       5'h08
`define CRCG_DEPTH_WIDE    5'h04
`define CRCG_DEPTH_MID     5'h08
`define CRCG_DEPTH_NARROW  5'h10
`define CRCG_FIFO_SLOTS    16
`define CRCG_BITS_PER_CLK  6'h02

`endif

// ==== crcg_pkg.sv ====
/*
 * types of the crc generator: fsm states, register port bundle, state.
 * assumes crcg_cfg.svh is compiled alongside.
 */
package crcg_pkg;

	// ==========================================================
	// engine states
	typedef enum logic [1:0] {
		CRCG_IDLE  = 2'b00,
		CRCG_SHIFT = 2'b01
	} crcg_fsm_t;

	// ==========================================================
	// register port request
	typedef struct packed {
		logic [2:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} crcg_bus_t;

	// ==========================================================
	// whole state of the generator
	typedef struct packed {
		logic              en;
		logic              idle_stop;
		logic              isel;
		logic              run;
		logic              lsb_first;
		logic [4:0]        wsel;
		logic [4:0]        psel;
		logic [31:0]       terms;
		logic [31:0]       stage;
		logic [31:0]       result;
		logic [15:0][31:0] fifo;
		logic [3:0]        wr_ptr;
		logic [3:0]        rd_ptr;
		logic [4:0]        count;
		crcg_fsm_t         fsm;
		logic [31:0]       sbuf;
		logic [5:0]        bits_left;
		logic              irq;
		logic [15:0]       rdata;
	} crcg_state_t;

endpackage

// ==== crcg_step.sv ====
/*
 * one bit step of the crc shift engine.
 * assumes the caller chains it for several bits per clock.
 */
module crcg_step (
	input  wire logic [31:0] crc_in,
	input  wire logic        data_bit_in,
	input  wire logic [31:0] terms_in,
	input  wire logic [4:0]  len_sel_in,
	output logic      [31:0] crc_out
);

	logic [31:0] len_mask;
	logic        fb;

	// ==========================================================
	// galois step
	always_comb begin
		len_mask = 32'hFFFFFFFF >> (5'h1F - len_sel_in); // RULE23
		fb = data_bit_in ^ crc_in[len_sel_in]; // RULE24
		// top term is implied: the bit shifted out is the x^n term
		crc_out = ((crc_in << 1) ^ ({32{fb}} & (terms_in | 32'h00000001)))
			& len_mask; // RULE2 RULE3 RULE4
	end

endmodule

// ==== crcg_top.sv ====
/*
 * programmable crc generator: registers, input fifo, two-bit engine.
 * assumes a same-clock register master and a same-clock idle indication.
 */
// Operation
// RULE1: polynomial order up to 32, chosen by a five-bit length field
// RULE2: each set term bit enables xor feedback at that engine position
// RULE3: constant x^0 feedback always applied, lowest term bit ignored
// RULE4: x^n term always implied, no stored bit for it
// RULE5: data words of 1 to 32 bits, chosen by five-bit width field
// RULE6: fifo depth 4 above width 15, 8 for 8..15, 16 below 8
// RULE7: smallest write is a byte, bits above the width ignored
// RULE8: word count rises only on write of the byte holding the word msb
// RULE9: software writes low data register before high data register
// RULE10: run and words waiting: pop one word into shift buffer, shift it
// RULE11: two bits per clock until word count reaches zero
// RULE12: full flag at depth for width, empty flag at count zero
// RULE13: enable low empties fifo and clears engine, data and result
// RULE14: software waits a cycle after data write before reading count
// RULE15: endian bit picks msb or lsb first; result stays non-reflected
// RULE16: select low: interrupt when word count goes from one to zero
// RULE17: select high: interrupt when engine clears run itself only
// RULE18: software clears results before start or leaves them to resume
// RULE19: software enables, configures, preloads, runs, then refills
// RULE20: control one: enable, idle stop, count, full, empty, sel, run, end
// RULE21: idle stop set halts the module while the chip idles
// RULE22: effective word width is width field plus one
// RULE23: effective polynomial length is length field plus one
// RULE24: shift register, data bit xor top bit feeds enabled terms
`include "crcg_cfg.svh"

module crcg_top import crcg_pkg::*; (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire crcg_bus_t   bus_in,
	input  wire logic        idle_mode_in,
	output logic      [15:0] rdata_out,
	output logic             irq_out
);

	crcg_state_t q;
	crcg_state_t d;
	logic [4:0]  depth;
	logic [31:0] wmask;
	logic        halted;
	logic        push_req;
	logic        push;
	logic [31:0] push_word;
	logic        pop;
	logic [31:0] pop_word;
	logic        finish;
	logic        bit_a;
	logic        bit_b;
	logic [31:0] step1;
	logic [31:0] step2;
	logic        full;
	logic        c1_wr;

	// ==========================================================
	// engine bit steps
	crcg_step u_step_a (
		.crc_in      (q.result),
		.data_bit_in (bit_a),
		.terms_in    (q.terms),
		.len_sel_in  (q.psel),
		.crc_out     (step1)
	);

	crcg_step u_step_b (
		.crc_in      (step1),
		.data_bit_in (bit_b),
		.terms_in    (q.terms),
		.len_sel_in  (q.psel),
		.crc_out     (step2)
	);

	// ==========================================================
	// sizing and input path
	always_comb begin
		if (q.wsel >= `CRCG_WIDE_MIN) begin
			depth = `CRCG_DEPTH_WIDE; // RULE6
		end else if (q.wsel >= `CRCG_MID_MIN) begin
			depth = `CRCG_DEPTH_MID; // RULE6
		end else begin
			depth = `CRCG_DEPTH_NARROW; // RULE6
		end
		wmask = 32'hFFFFFFFF >> (5'h1F - q.wsel); // RULE5 RULE22
		full = (q.count >= depth); // RULE12
		halted = q.idle_stop & idle_mode_in; // RULE21
		c1_wr = bus_in.wr && (bus_in.addr == `CRCG_ADR_CTRL1);
		// the high half takes the staged low half, so order matters
		push_req = 1'b0;
		push_word = {bus_in.wdata, q.stage[15:0]} & wmask; // RULE7
		if (q.en && bus_in.wr) begin
			if (bus_in.addr == `CRCG_ADR_DATA_LO
				&& q.wsel < `CRCG_WIDE_MIN) begin
				push_req = 1'b1; // RULE8
				push_word = {16'h0000, bus_in.wdata} & wmask; // RULE7
			end else if (bus_in.addr == `CRCG_ADR_DATA_HI
				&& q.wsel >= `CRCG_WIDE_MIN) begin
				push_req = 1'b1; // RULE8
			end
		end
		// a write into a full fifo is dropped
		push = push_req && !full; // RULE12
		bit_a = q.lsb_first ? q.sbuf[0] : q.sbuf[31]; // RULE15
		bit_b = q.lsb_first ? q.sbuf[1] : q.sbuf[30]; // RULE15
		pop_word = q.fifo[q.rd_ptr];
	end

	// ==========================================================
	// next state
	always_comb begin
		d = q;
		d.irq = 1'b0;
		d.rdata = 16'h0000;
		pop = 1'b0;
		finish = 1'b0;

		// engine
		if (q.en && q.run && !halted) begin
			case (q.fsm)
				CRCG_IDLE: begin
					if (q.count != 5'h00) begin
						pop = 1'b1; // RULE10
					end
				end
				CRCG_SHIFT: begin
					if (q.bits_left >= `CRCG_BITS_PER_CLK) begin
						d.result = step2; // RULE11
						d.bits_left = q.bits_left - `CRCG_BITS_PER_CLK;
						d.sbuf = q.lsb_first ? (q.sbuf >> 2)
							: (q.sbuf << 2); // RULE15
					end else begin
						d.result = step1;
						d.bits_left = 6'h00;
					end
					if (d.bits_left == 6'h00) begin
						if (q.count != 5'h00) begin
							pop = 1'b1; // RULE11
						end else begin
							finish = 1'b1; // RULE17
							d.run = 1'b0;
							d.fsm = CRCG_IDLE;
						end
					end
				end
				default: begin
					d.fsm = CRCG_IDLE;
				end
			endcase
		end
		if (pop) begin
			d.fsm = CRCG_SHIFT; // RULE10
			d.rd_ptr = q.rd_ptr + 4'h1;
			// msb-first words are left aligned so bit 31 leads
			d.sbuf = q.lsb_first ? pop_word
				: (pop_word << (5'h1F - q.wsel)); // RULE15
			d.bits_left = {1'b0, q.wsel} + 6'h01; // RULE22
		end
		if (push) begin
			d.fifo[q.wr_ptr] = push_word;
			d.wr_ptr = q.wr_ptr + 4'h1;
		end
		d.count = q.count + {4'h0, push} - {4'h0, pop}; // RULE10

		// interrupt events
		if (!q.isel && q.en && q.count == 5'h01 && d.count == 5'h00) begin
			d.irq = 1'b1; // RULE16
		end
		if (q.isel && finish) begin
			d.irq = 1'b1; // RULE17
		end

		// register writes; a software run write wins over completion
		if (bus_in.wr) begin
			if (c1_wr) begin
				d.en = bus_in.wdata[`CRCG_C1_EN]; // RULE20
				d.idle_stop = bus_in.wdata[`CRCG_C1_IDLE];
				d.isel = bus_in.wdata[`CRCG_C1_ISEL];
				d.run = bus_in.wdata[`CRCG_C1_RUN];
				d.lsb_first = bus_in.wdata[`CRCG_C1_LSB];
			end else if (bus_in.addr == `CRCG_ADR_CTRL2) begin
				d.wsel = bus_in.wdata[`CRCG_C2_WID_HI:`CRCG_C2_WID_LO];
				d.psel = bus_in.wdata[`CRCG_C2_LEN_HI:`CRCG_C2_LEN_LO];
			end else if (bus_in.addr == `CRCG_ADR_TERMS_LO) begin
				d.terms[15:0] = {bus_in.wdata[15:1], 1'b0}; // RULE3
			end else if (bus_in.addr == `CRCG_ADR_TERMS_HI) begin
				d.terms[31:16] = bus_in.wdata; // RULE1
			end else if (bus_in.addr == `CRCG_ADR_DATA_LO) begin
				d.stage[15:0] = bus_in.wdata;
			end else if (bus_in.addr == `CRCG_ADR_DATA_HI) begin
				d.stage[31:16] = bus_in.wdata;
			end else if (bus_in.addr == `CRCG_ADR_RES_LO) begin
				d.result[15:0] = bus_in.wdata;
			end else begin
				d.result[31:16] = bus_in.wdata;
			end
		end

		// disabled: flush data path, keep configuration
		if (!q.en) begin
			d.fifo = '0; // RULE13
			d.wr_ptr = 4'h0;
			d.rd_ptr = 4'h0;
			d.count = 5'h00;
			d.stage = 32'h00000000;
			d.result = 32'h00000000;
			d.sbuf = 32'h00000000;
			d.bits_left = 6'h00;
			d.fsm = CRCG_IDLE;
		end

		// reads answer in the next cycle
		if (bus_in.rd) begin
			if (bus_in.addr == `CRCG_ADR_CTRL1) begin
				d.rdata = {q.en, 1'b0, q.idle_stop, q.count, full,
					(q.count == 5'h00), q.isel, q.run, q.lsb_first,
					3'h0}; // RULE20 RULE12
			end else if (bus_in.addr == `CRCG_ADR_CTRL2) begin
				d.rdata = {3'h0, q.wsel, 3'h0, q.psel};
			end else if (bus_in.addr == `CRCG_ADR_TERMS_LO) begin
				d.rdata = q.terms[15:0];
			end else if (bus_in.addr == `CRCG_ADR_TERMS_HI) begin
				d.rdata = q.terms[31:16];
			end else if (bus_in.addr == `CRCG_ADR_DATA_LO) begin
				d.rdata = q.stage[15:0];
			end else if (bus_in.addr == `CRCG_ADR_DATA_HI) begin
				d.rdata = q.stage[31:16];
			end else if (bus_in.addr == `CRCG_ADR_RES_LO) begin
				d.rdata = q.result[15:0];
			end else begin
				d.rdata = q.result[31:16];
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata_out = q.rdata;
	assign irq_out = q.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_last_bits;
		q.en && q.run && !halted && q.fsm == CRCG_SHIFT
			&& q.bits_left <= 6'h02 && q.count == 5'h00 && !bus_in.wr;
	endsequence

	sequence s_stopped;
		!q.run && q.fsm == CRCG_IDLE;
	endsequence

	a_hi_push_count: assert property ( // RULE8
		(q.en && bus_in.wr && bus_in.addr == `CRCG_ADR_DATA_HI
			&& q.wsel >= 5'h10 && !full && !pop)
		|=> q.count == $past(q.count) + 5'h01)
		else $error("high data write did not count a word");

	a_lo_no_count: assert property ( // RULE8
		(q.en && bus_in.wr && bus_in.addr == `CRCG_ADR_DATA_LO
			&& q.wsel >= 5'h10 && !pop)
		|=> $stable(q.count))
		else $error("low data write counted a wide word");

	a_full_refuse: assert property ( // RULE12
		(q.en && push_req && full && !pop) |=> $stable(q.count))
		else $error("push into full fifo was taken");

	a_disable_clears: assert property ( // RULE13
		(!q.en && !c1_wr) |=> (q.count == 5'h00 && q.result == 32'h0
			&& q.fsm == CRCG_IDLE))
		else $error("disabled module kept data state");

	a_two_bit_rate: assert property ( // RULE11
		(q.en && q.run && !halted && q.fsm == CRCG_SHIFT
			&& q.bits_left > 6'h02)
		|=> q.bits_left == $past(q.bits_left) - 6'h02)
		else $error("engine did not shift two bits");

	a_drain_irq: assert property ( // RULE16
		(!q.isel && q.en && q.count == 5'h01) ##1 (q.count == 5'h00)
		|-> irq_out)
		else $error("missing drain interrupt");

	a_finish_irq: assert property ( // RULE17
		s_last_bits |=> s_stopped ##0 (irq_out == q.isel))
		else $error("completion did not stop with right interrupt");

	a_sw_stop_quiet: assert property ( // RULE17
		(c1_wr && !bus_in.wdata[`CRCG_C1_RUN] && q.isel
			&& q.fsm == CRCG_IDLE) |=> !irq_out)
		else $error("software stop raised an interrupt");

	a_idle_halt: assert property ( // RULE21
		(halted && q.en && !bus_in.wr) |=> $stable(q.result)
			&& $stable(q.count))
		else $error("engine moved while idle stopped");

endmodule

// ==== test_crcg_top.sv ====
/*
 * self-checking bench of the crc generator top level.
 * assumes crcg_cfg.svh and crcg_pkg are compiled first.
 */
`include "crcg_cfg.svh"

module test_crcg_top import crcg_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic [2:0]  a;
		logic [15:0] d;
		logic [15:0] e;
	} crcg_row_t;

	// ==========================================================
	// signals
	logic        clk_in;
	logic        rst_n_in;
	crcg_bus_t   bus_q;
	logic        idle_q;
	logic [15:0] rdata;
	logic        irq;
	int          bad_count;
	int          n_checks;
	int          k;
	logic [15:0] rd_v;
	logic [15:0] ctl;
	logic [31:0] exp_crc;
	crcg_row_t   rows [7] = '{'{3'h0, 16'h2028, 16'h2068},
		'{3'h1, 16'hFFFF, 16'h1F1F}, '{3'h2, 16'hFFFF, 16'hFFFE},
		'{3'h3, 16'hA5C3, 16'hA5C3}, '{3'h0, 16'hFFFF, 16'hA078},
		'{3'h6, 16'h1234, 16'h1234}, '{3'h0, 16'h0000, 16'h0040}};
	logic [1:0]  modes [3] = '{2'b01, 2'b11, 2'b00};
	logic [15:0] dat [3] = '{16'h5AA7, 16'h003C, 16'hC3F1};
	logic [4:0]  dw [3] = '{5'h10, 5'h0F, 5'h07};
	int          dep [3] = '{4, 8, 16};

	crcg_top i_dut (
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.bus_in       (bus_q),
		.idle_mode_in (idle_q),
		.rdata_out    (rdata),
		.irq_out      (irq)
	);

	initial clk_in = 1'b0;
	always #5 clk_in = ~clk_in;

	// ==========================================================
	// helpers
	task check(input logic [15:0] seen, input logic [15:0] e, input string w);
		n_checks++;
		if (seen !== e) begin
			bad_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, w, seen, e);
		end
	endtask

	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_in);
		bus_q.addr <= a;
		bus_q.wdata <= d;
		bus_q.wr <= 1'b1;
		@(posedge clk_in);
		bus_q.wr <= 1'b0;
	endtask

	// read data stands one cycle only, then idles at zero
	task rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk_in);
		bus_q.addr <= a;
		bus_q.rd <= 1'b1;
		@(posedge clk_in);
		bus_q.rd <= 1'b0;
		#1;
		d = rdata;
		@(posedge clk_in);
		#1;
		check(rdata, 16'h0000, "read data idle");
	endtask

	task push(input logic [4:0] ws, input logic [31:0] d);
		wr(`CRCG_ADR_DATA_LO, d[15:0]);
		if (ws >= 5'h10)
			wr(`CRCG_ADR_DATA_HI, d[31:16]);
	endtask

	task wait_irq(input int lim);
		k = 0;
		while (irq !== 1'b1 && k < lim) begin
			@(posedge clk_in);
			#1;
			k++;
		end
		check({15'h0000, irq}, 16'h0001, "interrupt");
		@(posedge clk_in);
		#1;
		check({15'h0000, irq}, 16'h0000, "irq pulse");
	endtask

	// bit-serial reference, msb-first register, len is the field value
	function automatic logic [31:0] crc_calc(input logic [31:0] r,
		input logic [31:0] d, input int w, input int len,
		input logic [31:0] t, input logic lsb);
		logic b;
		for (int j = 0; j < w; j++) begin
			b = lsb ? d[j] : d[w - 1 - j];
			r = (r << 1) ^ ((b ^ r[len]) ? (t | 32'h1) : 32'h0);
			r = r & 32'((64'h1 << (len + 1)) - 64'h1);
		end
		return r;
	endfunction

	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_in);
		bad_count++;
		stop_test;
	end

	// ==========================================================
	// main sequence
	initial begin
		rst_n_in = 1'b0;
		bus_q = '0;
		idle_q = 1'b0;
		bad_count = 0;
		n_checks = 0;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(3'(i), rd_v);
			check(rd_v, (i == 0) ? 16'h0040 : 16'h0000, "reset");
		end
		$display("test reset done");
		for (int i = 0; i < 7; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rd_v);
			check(rd_v, rows[i].e, "register row");
		end
		$display("test registers done");
		// x0 term left clear on purpose: it must still apply
		for (int i = 0; i < 3; i++) begin
			ctl = 16'h8000 | (modes[i][1] ? 16'h0008 : 16'h0000)
				| (modes[i][0] ? 16'h0020 : 16'h0000);
			wr(`CRCG_ADR_CTRL1, ctl);
			wr(`CRCG_ADR_CTRL2, 16'h070F);
			wr(`CRCG_ADR_TERMS_LO, 16'h1020);
			wr(`CRCG_ADR_TERMS_HI, 16'h0000);
			wr(`CRCG_ADR_RES_LO, 16'h0000);
			wr(`CRCG_ADR_RES_HI, 16'h0000);
			exp_crc = 32'h00000000;
			for (int j = 0; j < 3; j++) begin
				push(5'h07, {16'h0000, dat[j]});
				exp_crc = crc_calc(exp_crc, {16'h0000, dat[j]}, 8, 15,
					32'h00001020, modes[i][1]);
			end
			wr(`CRCG_ADR_CTRL1, ctl | 16'h0010);
			wait_irq(60);
			if (!modes[i][0])
				repeat (10) @(posedge clk_in);
			rd(`CRCG_ADR_RES_LO, rd_v);
			check(rd_v, exp_crc[15:0], "crc low");
			rd(`CRCG_ADR_RES_HI, rd_v);
			check(rd_v, 16'h0000, "crc high");
			rd(`CRCG_ADR_CTRL1, rd_v);
			check(rd_v, ctl | 16'h0040, "run cleared");
		end
		$display("test crc done");
		wr(`CRCG_ADR_CTRL1, 16'h0000);
		rd(`CRCG_ADR_RES_LO, rd_v);
		check(rd_v, 16'h0000, "result cleared");
		for (int i = 0; i < 3; i++) begin
			wr(`CRCG_ADR_CTRL1, 16'h0000);
			wr(`CRCG_ADR_CTRL1, 16'h8000);
			wr(`CRCG_ADR_CTRL2, {3'h0, dw[i], 8'h1F});
			for (int j = 0; j <= dep[i]; j++)
				push(dw[i], 32'hFFFFFFFF);
			rd(`CRCG_ADR_CTRL1, rd_v);
			check(rd_v, 16'h8080 | (16'(dep[i]) << 8), "full");
		end
		wr(`CRCG_ADR_CTRL1, 16'h0000);
		rd(`CRCG_ADR_CTRL1, rd_v);
		check(rd_v, 16'h0040, "disabled");
		$display("test depth done");
		wr(`CRCG_ADR_CTRL1, 16'h8000);
		wr(`CRCG_ADR_CTRL2, 16'h1F1F);
		wr(`CRCG_ADR_DATA_LO, 16'h1234);
		rd(`CRCG_ADR_CTRL1, rd_v);
		check(rd_v, 16'h8040, "low half");
		wr(`CRCG_ADR_DATA_HI, 16'h5678);
		rd(`CRCG_ADR_CTRL1, rd_v);
		check(rd_v, 16'h8100, "high half");
		wr(`CRCG_ADR_CTRL1, 16'h0000);
		$display("test word count done");
		// halted engine must keep its word until idle ends
		wr(`CRCG_ADR_CTRL1, 16'h8000);
		wr(`CRCG_ADR_CTRL2, 16'h070F);
		push(5'h07, 32'h000000A5);
		idle_q <= 1'b1;
		wr(`CRCG_ADR_CTRL1, 16'hA030);
		repeat (20) @(posedge clk_in);
		rd(`CRCG_ADR_CTRL1, rd_v);
		check(rd_v, 16'hA130, "idle halt");
		@(posedge clk_in);
		idle_q <= 1'b0;
		wait_irq(30);
		$display("test idle done");
		// software stop mid-word: no interrupt, result resumes later
		wr(`CRCG_ADR_CTRL2, 16'h1F1F);
		push(5'h1F, 32'hC001D00D);
		wr(`CRCG_ADR_CTRL1, 16'h8030);
		wr(`CRCG_ADR_CTRL1, 16'h8020);
		k = 0;
		repeat (30) begin
			@(posedge clk_in);
			#1;
			if (irq !== 1'b0)
				k++;
		end
		check(16'(k), 16'h0000, "quiet stop");
		rd(`CRCG_ADR_CTRL1, rd_v);
		check(rd_v, 16'h8060, "paused");
		wr(`CRCG_ADR_CTRL1, 16'h8030);
		wait_irq(30);
		exp_crc = crc_calc(crc_calc(32'h0, 32'hA5, 8, 15, 32'h1020, 1'b0),
			32'hC001D00D, 32, 31, 32'h1020, 1'b0);
		rd(`CRCG_ADR_RES_LO, rd_v);
		check(rd_v, exp_crc[15:0], "resumed low");
		rd(`CRCG_ADR_RES_HI, rd_v);
		check(rd_v, exp_crc[31:16], "resumed high");
		$display("test stop resume done");
		// reset after the run has finished returns control, width and low result registers to their reset values
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd(`CRCG_ADR_CTRL1, rd_v);
		check(rd_v, 16'h0040, "reset ctrl");
		rd(`CRCG_ADR_CTRL2, rd_v);
		check(rd_v, 16'h0000, "reset width");
		rd(`CRCG_ADR_RES_LO, rd_v);
		check(rd_v, 16'h0000, "reset result");
		$display("test reset again done");
		stop_test;
	end
endmodule
